// [pmc_pkg.sv]
// Constants, field layout and control record of the periodic modulo counter.
// Assumes a single 100 MHz system clock and a 32-bit Avalon-MM slave port.
package pmc_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam int         PMC_AW      = 4;
  localparam logic [3:0] PMC_OFS_SC  = 4'h0;
  localparam logic [3:0] PMC_OFS_CMP = 4'h4;
  localparam logic [3:0] PMC_OFS_CNT = 4'h8;

  // ----------------------------------------
  // Status/control field positions
  // ----------------------------------------
  localparam int PMC_SC_SRC_LSB = 14;
  localparam int PMC_SC_PS_LSB  = 8;
  localparam int PMC_SC_FLAG    = 7;
  localparam int PMC_SC_IE      = 6;
  localparam int PMC_SC_TOE     = 4;

  // ----------------------------------------
  // Encodings and reset values
  // ----------------------------------------
  localparam logic [1:0]  PMC_SRC_EXT  = 2'h0;
  localparam logic [1:0]  PMC_SRC_LPO  = 2'h1;
  localparam logic [1:0]  PMC_SRC_REF  = 2'h2;
  localparam logic [1:0]  PMC_SRC_BUS  = 2'h3;
  localparam logic [2:0]  PMC_PS_OFF   = 3'h0;
  localparam logic [15:0] PMC_CNT_RST  = 16'h0000;
  localparam logic [15:0] PMC_CMP_RST  = 16'h0000;
  localparam logic [15:0] PMC_CNT_ONE  = 16'h0001;
  localparam logic [11:0] PMC_PRE_RST  = 12'h000;
  localparam logic [11:0] PMC_PRE_ONE  = 12'h001;
  localparam logic [31:0] PMC_RD_ZERO  = 32'h0000_0000;

  // Divide ratios per prescaler code, code 0 off in both; LO set binary, HI set binary except decimal codes 6 and 7
  localparam logic [11:0] PMC_DIV_LO [8] = '{12'h000, 12'h001, 12'h002, 12'h004,
                                             12'h008, 12'h010, 12'h020, 12'h040};
  localparam logic [11:0] PMC_DIV_HI [8] = '{12'h000, 12'h080, 12'h100, 12'h200,
                                             12'h400, 12'h800, 12'h064, 12'h3e8};

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] clk_src;
    logic [2:0] pre_sel;
    logic       irq_en;
    logic       tog_en;
  } pmc_ctrl_s;

  localparam pmc_ctrl_s PMC_CTRL_RST = '{clk_src: PMC_SRC_EXT, pre_sel: PMC_PS_OFF,
                                         irq_en: 1'b0, tog_en: 1'b0};

  function automatic logic [11:0] pmc_divisor(input logic lks0, input logic [2:0] ps);
    return lks0 ? PMC_DIV_HI[ps] : PMC_DIV_LO[ps];
  endfunction

endpackage

// [pmc_top.sv]
// Periodic modulo counter with prescaler, match flag, interrupt and toggle pin.
// Assumes sys_clk at 100 MHz; oscillator inputs are asynchronous pins.
//
// Added by the designer: the Avalon-MM register port.

module pmc_top
  import pmc_pkg::*;
(
  input  wire logic                       sys_clk,
  input  wire logic                       sys_rst,
  input  wire logic [pmc_pkg::PMC_AW-1:0] avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  input  wire logic [3:0]                 avs_byteenable,
  output logic      [31:0]                avs_readdata,
  output logic                            avs_waitrequest,
  input  wire logic                       ext_osc_clk,
  input  wire logic                       low_power_osc,
  input  wire logic                       int_ref_clk,
  output logic                            match_irq,
  output logic                            toggle_out
);
  import pmc_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  pmc_ctrl_s   ctrl_reg,    ctrl_next;
  logic [15:0] cmp_reg,     cmp_next;
  logic [15:0] cmp_act_reg, cmp_act_next;
  logic [15:0] cnt_reg,     cnt_next;
  logic [11:0] pre_reg,     pre_next;
  logic        flag_reg,    flag_next;
  logic        irq_reg,     irq_next;
  logic        tog_reg,     tog_next;
  logic        wait_reg,    wait_next;
  logic [31:0] rdata_reg,   rdata_next;
  logic [2:0]  sync1_reg, sync2_reg, sync3_reg;

  // ----------------------------------------
  // Source synchronisers and edge detect
  // ----------------------------------------
  wire [2:0] src_pins = {int_ref_clk, low_power_osc, ext_osc_clk};
  wire [2:0] src_edge = sync2_reg & ~sync3_reg;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      sync3_reg <= 3'h0;
    end else begin
      sync1_reg <= src_pins;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  wire        done    = ~wait_reg & (avs_read | avs_write);
  wire        wr_sc   = done & avs_write & (avs_address == PMC_OFS_SC);
  wire        wr_cmp  = done & avs_write & (avs_address == PMC_OFS_CMP);
  wire [15:0] sc_img  = {ctrl_reg.clk_src, 3'h0, ctrl_reg.pre_sel, flag_reg,
                         ctrl_reg.irq_en, 1'b0, ctrl_reg.tog_en, 4'h0};
  wire [31:0] sc_wval = be_merge({16'h0000, sc_img}, avs_writedata, avs_byteenable);
  wire [31:0] cmp_wv  = be_merge({16'h0000, cmp_reg}, avs_writedata, avs_byteenable);

  wire pmc_ctrl_s wr_ctrl = '{clk_src: sc_wval[PMC_SC_SRC_LSB +: 2],
                              pre_sel: sc_wval[PMC_SC_PS_LSB +: 3],
                              irq_en:  sc_wval[PMC_SC_IE],
                              tog_en:  sc_wval[PMC_SC_TOE]};

  wire cfg_chg  = wr_sc & ((wr_ctrl.clk_src != ctrl_reg.clk_src) |
                           (wr_ctrl.pre_sel != ctrl_reg.pre_sel));
  wire ps_load  = wr_sc & (wr_ctrl.pre_sel != PMC_PS_OFF);
  wire flag_clr = wr_sc & sc_wval[PMC_SC_FLAG];

  // Read mux; reserved upper halves read zero
  wire [31:0] rd_mux = (avs_address == PMC_OFS_SC)  ? {16'h0000, sc_img}  :
                       (avs_address == PMC_OFS_CMP) ? {16'h0000, cmp_reg} :
                       (avs_address == PMC_OFS_CNT) ? {16'h0000, cnt_reg} :
                       PMC_RD_ZERO;

  // ----------------------------------------
  // Prescaler and counter
  // ----------------------------------------
  wire        src_tick = (ctrl_reg.clk_src == PMC_SRC_BUS) ? 1'b1 :
                         src_edge[ctrl_reg.clk_src];
  wire        run      = ctrl_reg.pre_sel != PMC_PS_OFF;
  wire [11:0] div      = pmc_divisor(ctrl_reg.clk_src[0], ctrl_reg.pre_sel);
  wire        pre_end  = pre_reg == (div - PMC_PRE_ONE);
  wire        tick     = run & src_tick & pre_end;
  wire        wrap     = tick & (cnt_reg == cmp_act_reg);

  assign ctrl_next    = wr_sc ? wr_ctrl : ctrl_reg;
  assign cmp_next     = wr_cmp ? cmp_wv[15:0] : cmp_reg;
  assign cmp_act_next = (wrap | ps_load) ? cmp_next : cmp_act_reg;
  assign pre_next     = cfg_chg ? PMC_PRE_RST :
                        (run & src_tick) ? (pre_end ? PMC_PRE_RST : pre_reg + PMC_PRE_ONE) :
                        pre_reg;
  assign cnt_next     = (cfg_chg | wrap) ? PMC_CNT_RST :
                        tick ? cnt_reg + PMC_CNT_ONE : cnt_reg;
  assign flag_next    = wrap | (flag_reg & ~flag_clr);
  assign irq_next     = flag_next & ctrl_next.irq_en;
  assign tog_next     = tog_reg ^ (wrap & ctrl_reg.tog_en);
  assign wait_next    = ~(wait_reg & (avs_read | avs_write));
  assign rdata_next   = (wait_reg & avs_read) ? rd_mux : rdata_reg;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      ctrl_reg    <= PMC_CTRL_RST;
      cmp_reg     <= PMC_CMP_RST;
      cmp_act_reg <= PMC_CMP_RST;
      cnt_reg     <= PMC_CNT_RST;
      pre_reg     <= PMC_PRE_RST;
      flag_reg    <= 1'b0;
      irq_reg     <= 1'b0;
      tog_reg     <= 1'b0;
    end else begin
      ctrl_reg    <= ctrl_next;
      cmp_reg     <= cmp_next;
      cmp_act_reg <= cmp_act_next;
      cnt_reg     <= cnt_next;
      pre_reg     <= pre_next;
      flag_reg    <= flag_next;
      irq_reg     <= irq_next;
      tog_reg     <= tog_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wait_reg  <= 1'b1;
      rdata_reg <= PMC_RD_ZERO;
    end else begin
      wait_reg  <= wait_next;
      rdata_reg <= rdata_next;
    end
  end

  assign avs_readdata    = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign match_irq       = irq_reg;
  assign toggle_out      = tog_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_wrap_zero;
    @(posedge sys_clk) disable iff (sys_rst)
    (tick && cnt_reg == cmp_act_reg) |=> (cnt_reg == PMC_CNT_RST);
  endproperty
  a_wrap_zero: assert property (p_wrap_zero) else $error("count not zero after wrap");

  property p_flag_on_wrap;
    @(posedge sys_clk) disable iff (sys_rst)
    wrap |=> flag_reg && cnt_reg == PMC_CNT_RST;
  endproperty
  a_flag_on_wrap: assert property (p_flag_on_wrap) else $error("flag missed wrap");

  property p_flag_clear;
    @(posedge sys_clk) disable iff (sys_rst)
    (flag_clr && !wrap) |=> !flag_reg && !match_irq;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

  property p_flag_keep;
    @(posedge sys_clk) disable iff (sys_rst)
    (flag_reg && !flag_clr) |=> flag_reg;
  endproperty
  a_flag_keep: assert property (p_flag_keep) else $error("flag lost");

  property p_irq;
    @(posedge sys_clk) disable iff (sys_rst)
    match_irq == (flag_reg && ctrl_reg.irq_en);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  property p_toggle;
    @(posedge sys_clk) disable iff (sys_rst)
    (wrap && ctrl_reg.tog_en) |=> toggle_out != $past(toggle_out);
  endproperty
  a_toggle: assert property (p_toggle) else $error("pin did not toggle");

  property p_off_hold;
    @(posedge sys_clk) disable iff (sys_rst)
    (!run && !wr_sc) |=> $stable(cnt_reg) && $stable(pre_reg);
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("counter moved while off");

  property p_cfg_clear;
    @(posedge sys_clk) disable iff (sys_rst)
    cfg_chg |=> cnt_reg == PMC_CNT_RST && pre_reg == PMC_PRE_RST;
  endproperty
  a_cfg_clear: assert property (p_cfg_clear) else $error("change did not clear");

  property p_cmp_latch;
    @(posedge sys_clk) disable iff (sys_rst)
    !(wrap || ps_load) |=> $stable(cmp_act_reg);
  endproperty
  a_cmp_latch: assert property (p_cmp_latch) else $error("compare loaded early");

  property p_step;
    @(posedge sys_clk) disable iff (sys_rst)
    (!tick && !cfg_chg) |=> $stable(cnt_reg);
  endproperty
  a_step: assert property (p_step) else $error("count moved without tick");

  property p_upper_zero;
    @(posedge sys_clk) disable iff (sys_rst)
    (!avs_waitrequest && avs_read && avs_address != PMC_OFS_SC) |->
      avs_readdata[31:16] == 16'h0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("reserved bits set");

  property p_tog_hold;
    @(posedge sys_clk) disable iff (sys_rst)
    !(wrap && ctrl_reg.tog_en) |=> $stable(toggle_out);
  endproperty
  a_tog_hold: assert property (p_tog_hold) else $error("pin moved without wrap");

  property p_flag_src;
    @(posedge sys_clk) disable iff (sys_rst)
    (!flag_reg && !wrap) |=> !flag_reg;
  endproperty
  a_flag_src: assert property (p_flag_src) else $error("flag set without wrap");

  property p_cnt_inc;
    @(posedge sys_clk) disable iff (sys_rst)
    (tick && !wrap && !cfg_chg) |=> cnt_reg == $past(cnt_reg) + PMC_CNT_ONE;
  endproperty
  a_cnt_inc: assert property (p_cnt_inc) else $error("count did not step by one");

  property p_cmp_hold;
    @(posedge sys_clk) disable iff (sys_rst)
    !wr_cmp |=> $stable(cmp_reg);
  endproperty
  a_cmp_hold: assert property (p_cmp_hold) else $error("compare changed unwritten");

  property p_ctrl_hold;
    @(posedge sys_clk) disable iff (sys_rst)
    !wr_sc |=> $stable(ctrl_reg);
  endproperty
  a_ctrl_hold: assert property (p_ctrl_hold) else $error("control changed unwritten");

  property p_pre_bound;
    @(posedge sys_clk) disable iff (sys_rst)
    run |-> pre_reg < div;
  endproperty
  a_pre_bound: assert property (p_pre_bound) else $error("prescaler beyond divisor");

  property p_wait_pulse;
    @(posedge sys_clk) disable iff (sys_rst)
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_pulse: assert property (p_wait_pulse) else $error("waitrequest low too long");

  property p_rdata_hold;
    @(posedge sys_clk) disable iff (sys_rst)
    !(avs_waitrequest && avs_read) |=> $stable(avs_readdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

  property p_act_load;
    @(posedge sys_clk) disable iff (sys_rst)
    (wrap || ps_load) |=> cmp_act_reg == cmp_reg;
  endproperty
  a_act_load: assert property (p_act_load) else $error("compare not loaded");

  property p_bus_run;
    @(posedge sys_clk) disable iff (sys_rst)
    (run && ctrl_reg.clk_src == PMC_SRC_BUS && !cfg_chg) |=> pre_reg != $past(pre_reg);
  endproperty
  a_bus_run: assert property (p_bus_run) else $error("bus clock not counted");

endmodule

// [tb_top.sv]
// Self-checking bench for the periodic modulo counter.
// Assumes pmc_pkg and pmc_top compiled first; bench drives every pin itself.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pmc_pkg::*;

  // ----------------------------------------
  // Signals and design
  // ----------------------------------------
  logic                sys_clk;
  logic                sys_rst;
  logic [PMC_AW-1:0]   avs_address;
  logic                avs_read;
  logic                avs_write;
  logic [31:0]         avs_writedata;
  logic [31:0]         avs_readdata;
  logic                avs_waitrequest;
  logic [2:0]          osc;
  logic                match_irq;
  logic                toggle_out;
  int                  mismatches;
  int                  tests_run;
  logic [31:0]         seed;
  int                  m_src, m_ps, m_ie, m_toe, m_flag, m_tog, m_cnt, m_cmp, m_act, m_pre;
  int                  dlo[8] = '{0, 1, 2, 4, 8, 16, 32, 64};
  int                  dhi[8] = '{0, 128, 256, 512, 1024, 2048, 100, 1000};

  pmc_top u_pmc_top (.sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ext_osc_clk(osc[0]), .low_power_osc(osc[1]), .int_ref_clk(osc[2]),
    .match_irq(match_irq), .toggle_out(toggle_out));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (n >= 50) chk("bus answer", 1, 0);
  endtask

  // Model of one prescaler input edge
  function automatic void mtick();
    if (m_ps == 0) return;
    m_pre++;
    if (m_pre >= (m_src[0] ? dhi[m_ps] : dlo[m_ps])) begin
      m_pre = 0;
      if (m_cnt == m_act) begin
        m_cnt = 0;
        m_flag = 1;
        if (m_toe != 0) m_tog ^= 1;
        m_act = m_cmp;
      end else m_cnt++;
    end
  endfunction

  task automatic pulse(input int s, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      osc[s] <= 1'b1;
      repeat (2) @(posedge sys_clk);
      osc[s] <= 1'b0;
      @(posedge sys_clk);
      if (s == m_src) mtick();
    end
    repeat (6) @(posedge sys_clk);
  endtask

  task automatic wsc(input int s, input int p, input int fw, input int ie, input int toe);
    logic [31:0] q;
    if (s != m_src || p != m_ps) begin
      m_pre = 0;
      m_cnt = 0;
    end
    m_src = s;
    m_ps = p;
    m_ie = ie;
    m_toe = toe;
    if (fw != 0) m_flag = 0;
    if (p != 0) m_act = m_cmp;
    bus(1, PMC_OFS_SC, (s << 14) | (p << 8) | (fw << 7) | (ie << 6) | (toe << 4), q);
  endtask

  task automatic wcmp(input logic [31:0] v);
    logic [31:0] q;
    m_cmp = v[15:0];
    bus(1, PMC_OFS_CMP, v, q);
  endtask

  task automatic verify();
    logic [31:0] q;
    bus(0, PMC_OFS_SC, 0, q);
    chk("status", (m_src << 14) | (m_ps << 8) | (m_flag << 7) | (m_ie << 6) |
        (m_toe << 4), q);
    bus(0, PMC_OFS_CNT, 0, q);
    chk("count", m_cnt, q);
    chk("irq", m_flag & m_ie, match_irq);
    chk("toggle", m_tog, toggle_out);
  endtask

  // ----------------------------------------
  // Clock, watchdog, sequence
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (80000) @(posedge sys_clk);
    mismatches++;
    give_verdict();
  end

  initial begin
    logic [31:0] q;
    int          c;
    seed = 32'h0001_45eb;
    sys_rst = 1'b1;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    osc = '0;
    mismatches = 0;
    tests_run = 0;
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    verify();
    bus(0, PMC_OFS_CMP, 0, q);
    chk("compare reset", 0, q);
    wcmp(32'hdead_beef);
    bus(0, PMC_OFS_CMP, 0, q);
    chk("compare", 32'h0000_beef, q);
    bus(1, PMC_OFS_CNT, 32'hffff_ffff, q);
    verify();
    bus(0, 4'hc, 0, q);
    chk("unmapped", 0, q);
    wcmp(0);
    wsc(3, 1, 0, 1, 0);
    repeat (140) @(posedge sys_clk);
    m_flag = 1;
    verify();
    wsc(0, 0, 0, 1, 0);
    wsc(0, 0, 1, 1, 0);
    verify();
    wsc(0, 1, 0, 1, 1);
    pulse(0, 1);
    wsc(0, 1, 0, 1, 1);
    verify();
    for (int i = 0; i < 8; i++) begin
      wcmp(rnd() & 32'h7);
      if (i % 2 == 1) wsc(0, 1, 1, 1, 1);
      pulse(0, 1 + rnd() % 20);
      verify();
    end
    wsc(0, 0, 1, 1, 1);
    pulse(0, 5);
    verify();
    wcmp(32'h0000_ffff);
    for (int s = 1; s < 3; s++) begin
      for (c = 1; c < 8; c++) begin
        wsc(s, c, 1, 0, 0);
        pulse(s, 2 * (s == 1 ? dhi[c] : dlo[c]) - 1);
        pulse(s == 1 ? 2 : 0, 3);
        verify();
      end
    end
    give_verdict();
  end
endmodule
